// [design/pcsld_pkg.sv]
/*
 * Shared constants of the plasma column shift and latch driver.
 * Assumes nothing of its surroundings; the driver and the bench import it.
 */
package pcsld_pkg;

    // Column count and chain geometry
    localparam int STAGE_COUNT = 32;
    localparam int CHAIN_STEP = 2;
    localparam int ODD_FIRST_IDX = 0;
    localparam int EVEN_FIRST_IDX = 1;
    localparam int ODD_LAST_IDX = 30;
    localparam int EVEN_LAST_IDX = 31;
    localparam int CHAIN_DEPTH = 16;

    // Control pins carried through one synchroniser
    localparam int CTRL_WIDTH = 3;
    localparam int CTRL_LATCH_IDX = 0;
    localparam int CTRL_FORCE_IDX = 1;
    localparam int CTRL_GATE_IDX = 2;

    // Output and latch values
    localparam logic [STAGE_COUNT-1:0] DRIVE_ALL_OFF = 32'h0000_0000;
    localparam logic [STAGE_COUNT-1:0] DRIVE_ALL_ON = 32'hFFFF_FFFF;
    localparam logic [STAGE_COUNT-1:0] LATCH_RESET = 32'h0000_0000;

endpackage

// [design/pcsld_sync.sv]
/*
 * Two-flop level synchroniser, one per bit of a bus.
 * Assumes each bit is a level that is stable for several clock cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module pcsld_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] metaStage;

    // First flop feeds only the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            metaStage <= '0;
            syncOut <= '0;
        end else begin
            metaStage <= asyncIn;
            syncOut <= metaStage;
        end
    end

endmodule

`default_nettype wire

// [design/pcsld_driver.sv]
/*
 * Plasma column driver: two 16-stage serial chains on the shift clock,
 * 32 hold latches and the output gating on the system clock.
 * Assumes the shift clock comes from the display controller and may stop
 * between loads; control pins are asynchronous to clk.
 */
// What this block does
// (R1) Each shift-clock fall advances both chains
// (R2) Even stages shift upward from even input
// (R3) Odd stages shift upward from odd input
// (R4) No shift-clock fall, stages hold
// (R5) Latch enable high: latches follow stages
// (R6) Latch enable falling: latches hold value
// (R7) Gate high, force high: all on
// (R8) Gate high, force low: follow latches
// (R9) Gate low: all outputs off
// (R10) Chain outputs show stages 31, 32
// (R11) Controller may cascade devices on chain outputs
// (R12) Controller splits words into odd/even streams
// (R13) Stage n feeds latch n, output n
`timescale 1ns/100ps
`default_nettype none

module pcsld_driver
    import pcsld_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Shift link from the display controller
    input wire logic shiftClk,
    input wire logic serial_in_odd,
    input wire logic serial_in_even,
    // Control pins
    input wire logic latchEnable,
    input wire logic forceOn,
    input wire logic outputGate,
    // Cascade outputs
    output logic chain_out_odd,
    output logic chain_out_even,
    // Column outputs
    output logic [pcsld_pkg::STAGE_COUNT-1:0] column_drive_lines
);

    import pcsld_pkg::*;

    // Shift-clock domain: the two interleaved chains
    logic [STAGE_COUNT-1:0] shift_stages;
    logic [STAGE_COUNT-1:0] next_shift_stages;

    // System-clock domain
    logic [CTRL_WIDTH-1:0] ctrlPins;
    logic [CTRL_WIDTH-1:0] ctrlSync;
    logic [STAGE_COUNT-1:0] stageSync;
    logic [STAGE_COUNT-1:0] stageSyncLast;
    logic [STAGE_COUNT-1:0] stageMirror;
    logic [STAGE_COUNT-1:0] hold_latches;
    logic [STAGE_COUNT-1:0] next_hold_latches;
    logic [STAGE_COUNT-1:0] next_drive;
    logic latchOpen;
    logic forceSync;
    logic gateSync;
    logic stageSettled;

    // Chain next-state: lowest stage of each chain takes its serial input
    genvar i;
    generate
        for (i = 0; i < STAGE_COUNT; i++) begin : g_chain
            if (i == ODD_FIRST_IDX) begin : g_odd_head
                assign next_shift_stages[i] = serial_in_odd; // R3
            end else if (i == EVEN_FIRST_IDX) begin : g_even_head
                assign next_shift_stages[i] = serial_in_even; // R2
            end else begin : g_body
                assign next_shift_stages[i] = shift_stages[i-CHAIN_STEP]; // R2 R3
            end
        end
    endgenerate

    // Both chains move together on the shift-clock fall only
    always_ff @(negedge shiftClk) begin
        shift_stages <= next_shift_stages; // R1 R4
    end

    // Cascade outputs come straight from the top stages
    assign chain_out_odd = shift_stages[ODD_LAST_IDX]; // R10
    assign chain_out_even = shift_stages[EVEN_LAST_IDX]; // R10

    // Control pins into the system domain
    assign ctrlPins[CTRL_LATCH_IDX] = latchEnable;
    assign ctrlPins[CTRL_FORCE_IDX] = forceOn;
    assign ctrlPins[CTRL_GATE_IDX] = outputGate;

    pcsld_sync #(
        .WIDTH(CTRL_WIDTH)
    ) u_ctrl_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn(ctrlPins),
        .syncOut(ctrlSync)
    );

    // Stage word into the system domain
    pcsld_sync #(
        .WIDTH(STAGE_COUNT)
    ) u_stage_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn(shift_stages),
        .syncOut(stageSync)
    );

    assign latchOpen = ctrlSync[CTRL_LATCH_IDX];
    assign forceSync = ctrlSync[CTRL_FORCE_IDX];
    assign gateSync = ctrlSync[CTRL_GATE_IDX];

    // A word seen twice in a row is past any skew of a shift in flight
    assign stageSettled = (stageSync == stageSyncLast);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stageSyncLast <= LATCH_RESET;
            stageMirror <= LATCH_RESET;
        end else begin
            stageSyncLast <= stageSync;
            if (stageSettled) begin
                stageMirror <= stageSync; // R13
            end
        end
    end

    // Transparent while open, frozen once closed
    assign next_hold_latches = latchOpen ? stageMirror : hold_latches; // R5 R6

    // Gate low wins, then force, then latch contents bit for bit
    assign next_drive = !gateSync ? DRIVE_ALL_OFF : // R9
                        forceSync ? DRIVE_ALL_ON : // R7
                        hold_latches; // R8 R13

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hold_latches <= LATCH_RESET;
            column_drive_lines <= DRIVE_ALL_OFF;
        end else begin
            hold_latches <= next_hold_latches;
            column_drive_lines <= next_drive;
        end
    end

    // Checks on the system-clock side
    sequence s_gate_closed;
        !gateSync;
    endsequence

    sequence s_gate_forced;
        gateSync && forceSync;
    endsequence

    sequence s_gate_follow;
        gateSync && !forceSync;
    endsequence

    sequence s_latch_closed_two;
        !latchOpen ##1 !latchOpen;
    endsequence

    a_gate_forces_off: assert property ( // R9
        @(posedge clk) disable iff (!resetn)
        s_gate_closed |=> (column_drive_lines == DRIVE_ALL_OFF)
    ) else $error("outputs not all off while gate low");

    a_force_all_on: assert property ( // R7
        @(posedge clk) disable iff (!resetn)
        s_gate_forced |=> (column_drive_lines == DRIVE_ALL_ON)
    ) else $error("outputs not all on while forced");

    a_drive_follows_latch: assert property ( // R8
        @(posedge clk) disable iff (!resetn)
        s_gate_follow |=> (column_drive_lines == $past(hold_latches))
    ) else $error("outputs do not follow latches");

    a_latch_passes_stage: assert property ( // R5
        @(posedge clk) disable iff (!resetn)
        latchOpen |=> (hold_latches == $past(stageMirror))
    ) else $error("open latch does not pass stage word");

    a_latch_holds_closed: assert property ( // R6
        @(posedge clk) disable iff (!resetn)
        s_latch_closed_two |-> (hold_latches == $past(hold_latches))
    ) else $error("closed latch changed");

    a_mirror_settles: assert property ( // R13
        @(posedge clk) disable iff (!resetn)
        (stageSync == stageSyncLast) |=> (stageMirror == $past(stageSync))
    ) else $error("settled stage word not mirrored");

    // Checks on the shift-clock side.
    // The chains have no reset and hold unknowns until filled, so each shift
    // check looks sixteen falls ahead, where every stage it compares is loaded.
    a_odd_chain_shift: assert property ( // R3
        @(negedge shiftClk) disable iff (!resetn)
        1'b1 |-> ##16 ((shift_stages[ODD_FIRST_IDX] == $past(serial_in_odd))
            && (shift_stages[ODD_LAST_IDX] == $past(shift_stages[ODD_LAST_IDX-CHAIN_STEP])))
    ) else $error("odd chain did not shift");

    a_even_chain_shift: assert property ( // R2
        @(negedge shiftClk) disable iff (!resetn)
        1'b1 |-> ##16 ((shift_stages[EVEN_FIRST_IDX] == $past(serial_in_even))
            && (shift_stages[EVEN_LAST_IDX] == $past(shift_stages[EVEN_LAST_IDX-CHAIN_STEP])))
    ) else $error("even chain did not shift");

    a_chain_out_delay: assert property ( // R10
        @(negedge shiftClk) disable iff (!resetn)
        1'b1 |-> ##16 (chain_out_odd == $past(serial_in_odd, 16))
            && (chain_out_even == $past(serial_in_even, 16))
    ) else $error("chain output is not input sixteen falls late");

endmodule

`default_nettype wire

// [sim/pcsld_ctrl_model.sv]
/*
 * Display controller model: shifts 32-bit words into the two chains.
 * Assumes the bench calls sendWord; the shift clock idles high between frames.
 * Also stands in for a chained next device: it collects what leaves the chain outputs.
 */
`timescale 1ns/100ps
`default_nettype none

module pcsld_ctrl_model (
    // Link to the driver
    output logic shiftClk,
    output logic serialOdd,
    output logic serialEven,
    // Cascade side: what a chained device takes in
    input wire logic chainOdd,
    input wire logic chainEven,
    output logic [31:0] cascadeWord
);
    initial begin
        shiftClk = 1'b1;
        serialOdd = 1'b0;
        serialEven = 1'b1;
    end

    // 12 ns link period; the first pair sent ends in stages 31 and 32
    task automatic sendWord(input logic [31:0] word);
        #1.3;
        for (int k = 15; k >= 0; k--) begin
            serialOdd = word[2*k];
            serialEven = word[2*k+1];
            #6;
            // A chained device takes the pair standing just before this fall
            cascadeWord = {cascadeWord[29:0], chainEven, chainOdd};
            shiftClk = 1'b0;
            #6 shiftClk = 1'b1;
        end
        // Hold time over: the lines stop showing the last bit
        serialOdd = ~serialOdd;
        serialEven = ~serialEven;
    endtask
endmodule

`default_nettype wire

// [sim/plasma_column_shift_latch_driver_test.sv]
/*
 * Self-checking bench for the column driver.
 * Assumes the controller model drives the link; controls change on clk rises.
 */
`timescale 1ns/100ps
`default_nettype none

module plasma_column_shift_latch_driver_test;
    import pcsld_pkg::*;
    typedef struct packed {
        logic [31:0] word;
        logic le;
        logic fo;
        logic gate;
        logic [31:0] want;
    } pcsld_tb_row_t;
    localparam pcsld_tb_row_t ROWS [5] = '{
        '{32'hA5A5_1234, 1'b1, 1'b0, 1'b1, 32'hA5A5_1234},
        '{32'h8000_0001, 1'b1, 1'b0, 1'b1, 32'h8000_0001},
        '{32'h0F0F_F0F0, 1'b1, 1'b1, 1'b1, DRIVE_ALL_ON},
        '{32'h7FFF_FFFE, 1'b1, 1'b0, 1'b0, DRIVE_ALL_OFF},
        '{32'h1357_9BDF, 1'b1, 1'b1, 1'b0, DRIVE_ALL_OFF}};
    localparam logic [31:0] W1 = 32'hC3C3_3C3C;
    localparam logic [31:0] W2 = 32'h2468_ACE0;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic latchEnable = 1'b1;
    logic forceOn = 1'b0;
    logic outputGate = 1'b1;
    logic shiftClk, serialOdd, serialEven, chainOdd, chainEven;
    logic [31:0] drive;
    logic [31:0] cascade;
    int miscompares = 0;
    int nChecks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    pcsld_ctrl_model u_ctrl (.shiftClk(shiftClk), .serialOdd(serialOdd), .serialEven(serialEven),
        .chainOdd(chainOdd), .chainEven(chainEven), .cascadeWord(cascade));

    pcsld_driver u_dut (.clk(clk), .resetn(resetn), .shiftClk(shiftClk), .serial_in_odd(serialOdd),
        .serial_in_even(serialEven), .latchEnable(latchEnable), .forceOn(forceOn), .outputGate(outputGate),
        .chain_out_odd(chainOdd), .chain_out_even(chainEven), .column_drive_lines(drive));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        nChecks++;
        if (seen !== want) begin
            miscompares++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short; the tests need about 490 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        waitClk(7);
        check(drive, DRIVE_ALL_OFF);
        @(posedge clk);
        resetn <= 1'b1;
        waitClk(1);
        check(drive, DRIVE_ALL_OFF);
        $display("Reset test done");
        foreach (ROWS[i]) begin
            @(posedge clk);
            latchEnable <= ROWS[i].le;
            forceOn <= ROWS[i].fo;
            outputGate <= ROWS[i].gate;
            u_ctrl.sendWord(ROWS[i].word);
            waitClk(12);
            check(drive, ROWS[i].want);
            check({chainEven, chainOdd}, ROWS[i].word[31:30]);
            $display("Row test %0d done", i);
        end
        @(posedge clk);
        forceOn <= 1'b0;
        outputGate <= 1'b1;
        u_ctrl.sendWord(W1);
        waitClk(12);
        check(drive, W1);
        check(cascade, ROWS[4].word);
        @(posedge clk);
        latchEnable <= 1'b0;
        waitClk(6);
        u_ctrl.sendWord(W2);
        waitClk(12);
        check(drive, W1);
        check({chainEven, chainOdd}, W2[31:30]);
        check(cascade, W1);
        @(posedge clk);
        outputGate <= 1'b0;
        waitClk(6);
        check(drive, DRIVE_ALL_OFF);
        @(posedge clk);
        outputGate <= 1'b1;
        forceOn <= 1'b1;
        waitClk(6);
        check(drive, DRIVE_ALL_ON);
        @(posedge clk);
        forceOn <= 1'b0;
        latchEnable <= 1'b1;
        waitClk(12);
        check(drive, W2);
        check({chainEven, chainOdd}, W2[31:30]);
        $display("Latch hold test done");
        // Reset in mid-run clears the outputs but leaves the chains alone
        @(posedge clk);
        resetn <= 1'b0;
        waitClk(4);
        check(drive, DRIVE_ALL_OFF);
        check({chainEven, chainOdd}, W2[31:30]);
        @(posedge clk);
        resetn <= 1'b1;
        waitClk(1);
        check(drive, DRIVE_ALL_OFF);
        waitClk(12);
        check(drive, W2);
        $display("Mid-run reset test done");
        conclude();
    end
endmodule

`default_nettype wire
